// ===== common/tb_pkg.sv
package tb_pkg;
    // Register indices on the byte-wide register port.
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PERIOD_LO = 4'h1;
    localparam logic [3:0] ADDR_PERIOD_HI = 4'h2;
    localparam logic [3:0] ADDR_PHASE_LO = 4'h3;
    localparam logic [3:0] ADDR_PHASE_HI = 4'h4;
    localparam logic [3:0] ADDR_DUTY_LO = 4'h5;
    localparam logic [3:0] ADDR_DUTY_HI = 4'h6;
    localparam logic [3:0] ADDR_FALL_SRC = 4'h7;
    localparam logic [3:0] ADDR_PERIOD_SRC = 4'h8;
    localparam logic [3:0] ADDR_RISE_SRC = 4'h9;
    localparam logic [3:0] ADDR_IRQ = 4'ha;
    localparam logic [3:0] ADDR_COUNT_LO = 4'hb;
    localparam logic [3:0] ADDR_COUNT_HI = 4'hc;

    // Control register bit positions.
    localparam int CTL_ENABLE = 7;
    localparam int CTL_LOAD = 6;

    // Interrupt register flag positions.
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_PERIOD = 1;
    localparam int IRQ_DUTY = 2;
    localparam int IRQ_PHASE = 3;

    // Source select bit positions: time base, pin, comparators one to three.
    localparam int SRC_TIMEBASE = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_CMP1 = 2;
    localparam int SRC_CMP2 = 3;
    localparam int SRC_CMP3 = 4;
    localparam int SRC_WIDTH = 5;

    // Reset values and counter constants.
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COUNTER_ALL_ONES = 16'hffff;
    localparam logic [15:0] COUNTER_STEP = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [SRC_WIDTH-1:0] SRC_DEFAULT = 5'h01;

    // One set of compare values that travel together.
    typedef struct packed {
        logic [15:0] period;
        logic [15:0] phase;
        logic [15:0] duty;
    } compare_set_t;

    // Events handed to the output stage.
    typedef struct packed {
        logic period;
        logic rise;
        logic fall;
    } pwm_events_t;
endpackage

// ===== rtl/edge_catch.sv
// Two-flop synchroniser per asynchronous source followed by a rising edge detector.
module edge_catch
    import tb_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;

    // The first stage feeds only the second one, so no logic sees a metastable level.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta <= '0;
            sync <= '0;
            last <= '0;
        end else begin
            meta <= raw;
            sync <= meta;
            last <= sync;
        end
    end

    // Events trigger on the rising edge only; a held level fires once.
    assign rise = sync & ~last;
endmodule // edge_catch

// ===== rtl/pwm_time_base_event_gen.sv
// The implementer's own choices: the register addresses and strobed register access.
module pwm_time_base_event_gen
    import tb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic event_input_pin,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic comparator_three,
    output pwm_events_t events,
    output logic drive_active,
    output logic rise_blank_start,
    output logic dead_band_start
);
    // Software-side registers.
    logic [7:0] module_control_reg;
    compare_set_t pending;
    compare_set_t active;
    logic [SRC_WIDTH-1:0] falling_source_select;
    logic [SRC_WIDTH-1:0] period_source_select;
    logic [SRC_WIDTH-1:0] rising_source_select;
    logic [3:0] time_base_irq_reg;
    logic [15:0] time_base_counter;
    logic clear_pending;
    logic fall_seen;
    logic rise_seen;
    logic [7:0] next_rdata;

    wire module_enable_bit = module_control_reg[CTL_ENABLE];
    wire buffer_load_request = module_control_reg[CTL_LOAD];

    // Synchronised edges of pin and comparators, in source select order above bit 0.
    logic [3:0] async_rise;
    edge_catch #(
        .WIDTH(4)
    ) u_edge_catch (
        .mclk(mclk),
        .rst_b(rst_b),
        .raw({comparator_three, comparator_two, comparator_one, event_input_pin}),
        .rise(async_rise)
    );

    // Compare matches against the active copies only; the zero after a clear is a real count.
    wire period_match = module_enable_bit
        && (time_base_counter == active.period);
    wire phase_match = module_enable_bit
        && (time_base_counter == active.phase);
    // A duty value the counter never reaches simply never matches.
    wire duty_match = module_enable_bit
        && (time_base_counter == active.duty);

    // Event source vectors: bit 0 is the time base match.
    wire [SRC_WIDTH-1:0] period_srcs = {async_rise, period_match};
    wire [SRC_WIDTH-1:0] rise_srcs = {async_rise, phase_match};
    wire [SRC_WIDTH-1:0] fall_srcs = {async_rise, duty_match};

    // Raw events before per-period qualification.
    wire period_event = module_enable_bit && |(period_srcs & period_source_select);
    wire fall_raw = module_enable_bit && |(fall_srcs & falling_source_select);
    wire rise_raw = module_enable_bit && |(rise_srcs & rising_source_select);

    // First falling event only; a rise in the same cycle as the fall still counts,
    // so duty equal to phase yields coincident events and no asserted output.
    wire fall_qual = fall_raw && !fall_seen;
    wire rise_qual = rise_raw && !rise_seen && !fall_seen;

    wire overflow_event = module_enable_bit
        && (time_base_counter == COUNTER_ALL_ONES) && !period_event;

    wire load_now = period_event && buffer_load_request;

    wire wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
    wire wr_irq = reg_wr && (reg_addr == ADDR_IRQ);

    // Counter: clears on the edge after a period event, counts on the edge after that.
    // Holding zero for a second cycle would stretch every period to the value plus two.
    always_ff @(posedge mclk) begin
        if (!rst_b || !module_enable_bit) begin
            time_base_counter <= COUNTER_RESET;
            clear_pending <= 1'b0;
        end else if (period_event) begin
            time_base_counter <= COUNTER_RESET;
            clear_pending <= 1'b1;
        end else begin
            time_base_counter <= time_base_counter + COUNTER_STEP;
            clear_pending <= 1'b0;
        end
    end

    // Per-period qualification state; a new period rearms both edges.
    always_ff @(posedge mclk) begin
        if (!rst_b || !module_enable_bit || period_event) begin
            fall_seen <= 1'b0;
            rise_seen <= 1'b0;
        end else begin
            fall_seen <= fall_seen | fall_qual;
            rise_seen <= rise_seen | rise_qual;
        end
    end

    // Drive level seen by the output stage; the fall wins over a coincident rise.
    always_ff @(posedge mclk) begin
        if (!rst_b || !module_enable_bit) begin
            drive_active <= 1'b0;
        end else if (fall_qual) begin
            drive_active <= 1'b0;
        end else if (rise_qual) begin
            drive_active <= 1'b1;
        end
    end

    // Event strobes are combinational so the output stage reacts at once.
    assign events = '{period: period_event, rise: rise_qual, fall: fall_qual};
    assign rise_blank_start = fall_qual;
    assign dead_band_start = fall_qual;
    // Effective duty follows from the match timing; no divider is built.

    // Pending and active compare sets move together at a loaded period event.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pending <= '0;
            active <= '0;
        end else begin
            if (reg_wr && reg_addr == ADDR_PERIOD_LO) pending.period[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_PERIOD_HI) pending.period[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_PHASE_LO) pending.phase[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_PHASE_HI) pending.phase[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_DUTY_LO) pending.duty[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_DUTY_HI) pending.duty[15:8] <= reg_wdata;
            if (load_now) begin
                active <= pending;
            end
        end
    end

    // Control and source select registers; the load bit self-clears on transfer unless a control write lands in that cycle.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            module_control_reg <= BYTE_ZERO;
            falling_source_select <= SRC_DEFAULT;
            period_source_select <= SRC_DEFAULT;
            rising_source_select <= SRC_DEFAULT;
        end else begin
            if (wr_ctl) begin
                module_control_reg <= reg_wdata;
            end else if (load_now) begin
                module_control_reg[CTL_LOAD] <= 1'b0;
            end
            if (reg_wr && reg_addr == ADDR_FALL_SRC) begin
                falling_source_select <= reg_wdata[SRC_WIDTH-1:0];
            end
            if (reg_wr && reg_addr == ADDR_PERIOD_SRC) begin
                period_source_select <= reg_wdata[SRC_WIDTH-1:0];
            end
            if (reg_wr && reg_addr == ADDR_RISE_SRC) begin
                rising_source_select <= reg_wdata[SRC_WIDTH-1:0];
            end
        end
    end

    // Flags: a hardware set wins over a write-zero clear in the same cycle.
    wire [3:0] flag_set;
    assign flag_set[IRQ_OVERFLOW] = overflow_event;
    assign flag_set[IRQ_PERIOD] = period_match;
    assign flag_set[IRQ_DUTY] = duty_match;
    assign flag_set[IRQ_PHASE] = phase_match;
    always_ff @(posedge mclk) begin
        if (!rst_b || !module_enable_bit) begin
            time_base_irq_reg <= '0;
        end else if (wr_irq) begin
            time_base_irq_reg <= reg_wdata[3:0] | flag_set;
        end else begin
            time_base_irq_reg <= time_base_irq_reg | flag_set;
        end
    end

    // Read mux; unmapped indices read zero.
    always_comb begin
        case (reg_addr)
            ADDR_CONTROL: next_rdata = module_control_reg;
            ADDR_PERIOD_LO: next_rdata = pending.period[7:0];
            ADDR_PERIOD_HI: next_rdata = pending.period[15:8];
            ADDR_PHASE_LO: next_rdata = pending.phase[7:0];
            ADDR_PHASE_HI: next_rdata = pending.phase[15:8];
            ADDR_DUTY_LO: next_rdata = pending.duty[7:0];
            ADDR_DUTY_HI: next_rdata = pending.duty[15:8];
            ADDR_FALL_SRC: next_rdata = {3'h0, falling_source_select};
            ADDR_PERIOD_SRC: next_rdata = {3'h0, period_source_select};
            ADDR_RISE_SRC: next_rdata = {3'h0, rising_source_select};
            ADDR_IRQ: next_rdata = {4'h0, time_base_irq_reg};
            ADDR_COUNT_LO: next_rdata = time_base_counter[7:0];
            ADDR_COUNT_HI: next_rdata = time_base_counter[15:8];
            default: next_rdata = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata <= BYTE_ZERO;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : BYTE_ZERO;
        end
    end

    // Assertions.
    a_fall_once: assert property (@(posedge mclk) disable iff (!rst_b)
        fall_seen && !period_event |-> !events.fall)
        else $error("second falling event in one period");
    a_rise_after_fall: assert property (@(posedge mclk) disable iff (!rst_b)
        fall_seen |-> !events.rise)
        else $error("rising event after falling event");
    a_counter_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        period_event && module_enable_bit |=> time_base_counter == COUNTER_RESET
        ##1 (!module_enable_bit || $past(period_event) || $past(!module_enable_bit)
        || time_base_counter == COUNTER_STEP))
        else $error("counter did not clear then resume");
    a_counter_step: assert property (@(posedge mclk) disable iff (!rst_b)
        module_enable_bit && !period_event && !clear_pending ##1 module_enable_bit
        |-> time_base_counter == $past(time_base_counter) + COUNTER_STEP)
        else $error("counter did not step by one");
    a_disable_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        !module_enable_bit |=> time_base_counter == COUNTER_RESET)
        else $error("counter not reset while disabled");
    a_load_moves: assert property (@(posedge mclk) disable iff (!rst_b)
        load_now |=> active == $past(pending) && !module_control_reg[CTL_LOAD])
        else $error("compare set not transferred");
    a_hold_active: assert property (@(posedge mclk) disable iff (!rst_b)
        !load_now |=> active == $past(active))
        else $error("active compare changed without load");
    a_period_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        period_match && module_enable_bit |=> time_base_irq_reg[IRQ_PERIOD])
        else $error("period flag not set");
    a_fall_blank: assert property (@(posedge mclk) disable iff (!rst_b)
        events.fall |-> rise_blank_start && dead_band_start ##1 !drive_active)
        else $error("falling event did not end pulse");
endmodule // pwm_time_base_event_gen

// ===== verif/ext_event_model.sv
// Far side of the block: comparators, event pin and the output stage.
module ext_event_model (
    input wire logic mclk,
    input wire logic drive_active,
    output logic event_input_pin,
    output logic comparator_one,
    output logic comparator_two,
    output logic comparator_three
);
    timeunit 1ns;
    timeprecision 1ps;
    int high_cycles = 0;

    // All asynchronous sources start low so no edge is seen at reset.
    initial begin
        {comparator_three, comparator_two, comparator_one, event_input_pin} = 4'h0;
    end

    // Edges land mid-cycle because these sources have no clock of their own.
    // Each level is held four cycles so the two-flop synchroniser sees it.
    task automatic pulse(input logic [3:0] mask);
        #3;
        {comparator_three, comparator_two, comparator_one, event_input_pin} = mask;
        repeat (4) @(posedge mclk);
        #4;
        {comparator_three, comparator_two, comparator_one, event_input_pin} = 4'h0;
        repeat (4) @(posedge mclk);
    endtask

    // Output stage: counts the cycles in which the drive is asserted.
    always @(posedge mclk) begin
        if (drive_active === 1'b1) begin
            high_cycles <= high_cycles + 1;
        end
    end
endmodule // ext_event_model

// ===== verif/tb_pwm_time_base_event_gen.sv
module tb_pwm_time_base_event_gen
    import tb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic event_input_pin, comparator_one, comparator_two, comparator_three;
    pwm_events_t ev;
    logic drive_active, rbs, dbs;
    int bad_count = 0;
    int n_checks = 0;
    int n_per = 0;
    int len = 0, nr = 0, nf = 0, nh = 0, h0 = 0;
    int last_len, last_rise, last_fall, last_high;
    logic [15:0] p, ph, d;
    logic [7:0] v;

    always #5 mclk = ~mclk;

    pwm_time_base_event_gen u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_input_pin(event_input_pin), .comparator_one(comparator_one),
        .comparator_two(comparator_two), .comparator_three(comparator_three),
        .events(ev), .drive_active(drive_active), .rise_blank_start(rbs),
        .dead_band_start(dbs));
    ext_event_model u_ext (.mclk(mclk), .drive_active(drive_active),
        .event_input_pin(event_input_pin), .comparator_one(comparator_one),
        .comparator_two(comparator_two), .comparator_three(comparator_three));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
        end
    endtask

    // Per-period tallies, sampled on the falling edge where the pulses have settled.
    always @(negedge mclk) begin
        if (ev.period === 1'b1) begin
            last_len = len + 1;
            last_rise = nr;
            last_fall = nf;
            last_high = nh;
            {len, nr, nf, nh} = '0;
            n_per++;
        end else begin
            len++;
        end
        nr += int'(ev.rise === 1'b1);
        nf += int'(ev.fall === 1'b1);
        nh += int'(drive_active === 1'b1);
        chk({14'h0, rbs, dbs}, {14'h0, ev.fall, ev.fall}, "timer starts");
    end

    // Register bus master: one-cycle strobes, data read in the following cycle.
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] x);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        x = reg_rdata;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] x);
        wr(a, x[7:0]);
        wr(a + 4'h1, x[15:8]);
    endtask
    task automatic setup(input logic [15:0] pp, input logic [15:0] pph, input logic [15:0] pd,
            input logic load);
        wr16(ADDR_PERIOD_LO, pp);
        wr16(ADDR_PHASE_LO, pph);
        wr16(ADDR_DUTY_LO, pd);
        if (load) begin
            wr(ADDR_CONTROL, 8'hc0);
        end
    endtask
    // Waiting is bounded so a dead time base cannot hang the run.
    task automatic wait_per(input int n);
        int t;
        t = n_per + n;
        for (int k = 0; k < 2000 && n_per < t; k++) @(posedge mclk);
        chk(16'(n_per >= t), 16'h1, "period events");
    endtask
    task automatic check_shape(input logic [15:0] pp, input logic [15:0] pph,
            input logic [15:0] pd);
        chk(16'(last_len), pp + 16'h1, "period length");
        chk(16'(last_rise), 16'h1, "rise count");
        chk(16'(last_fall), 16'h1, "fall count");
        chk(16'(last_high), pd - pph, "drive width");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The longest stretch is the free-running wrap, 65536 cycles of a 10 ns clock.
    initial begin
        #900000;
        bad_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'h35c69990));
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        rd(ADDR_FALL_SRC, v);
        chk(v, {3'h0, SRC_DEFAULT}, "fall select reset");
        rd(ADDR_COUNT_LO, v);
        chk(v, BYTE_ZERO, "counter reset");
        rd(4'hd, v);
        chk(v, BYTE_ZERO, "unmapped read");
        $display("test reset done");
        p = 16'd20 + 16'($urandom % 40);
        ph = 16'd2 + 16'($urandom % 5);
        d = ph + 16'd1 + 16'($urandom % 10);
        setup(p, ph, d, 1'b1);
        wait_per(3);
        check_shape(p, ph, d);
        rd(ADDR_CONTROL, v);
        chk(v[7:6], 2'b10, "load bit clears");
        rd(ADDR_IRQ, v);
        chk(v[3:0], 4'he, "match flags");
        $display("test sync shape done");
        setup(p + 16'd7, ph + 16'd1, d + 16'd3, 1'b0);
        wait_per(3);
        check_shape(p, ph, d);
        wr(ADDR_CONTROL, 8'hc0);
        wait_per(3);
        check_shape(p + 16'd7, ph + 16'd1, d + 16'd3);
        $display("test buffered load done");
        setup(p, ph, ph, 1'b1);
        wait_per(3);
        h0 = u_ext.high_cycles;
        wait_per(2);
        chk(16'(u_ext.high_cycles - h0), 16'h0, "zero duty drive");
        chk(16'(last_fall), 16'h1, "zero duty fall");
        setup(p, ph, p + 16'd5, 1'b1);
        wait_per(3);
        chk(16'(last_fall), 16'h0, "full duty fall");
        $display("test duty limits done");
        setup(16'd80, 16'd40, 16'd85, 1'b1);
        for (int i = SRC_PIN; i <= SRC_CMP3; i++) begin
            wr(ADDR_FALL_SRC, 8'(1 << i));
            wait_per(2);
            u_ext.pulse(4'(1 << (i - 1)));
            u_ext.pulse(4'(1 << (i - 1)));
            wait_per(1);
            chk(16'(last_fall), 16'h1, "first fall only");
            chk(16'(last_rise), 16'h0, "rise after fall");
        end
        $display("test async falls done");
        wr(ADDR_PERIOD_SRC, 8'(1 << SRC_PIN));
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_IRQ, 8'h00);
        repeat (16'h1270) @(posedge mclk);
        rd(ADDR_COUNT_HI, v);
        chk(v, 8'h12, "counter high byte");
        u_ext.pulse(4'h1);
        rd(ADDR_COUNT_LO, v);
        chk(16'(v < 8'h20), 16'h1, "async period reset");
        rd(ADDR_IRQ, v);
        chk(v[IRQ_OVERFLOW], 1'b0, "no early wrap");
        repeat (65536) @(posedge mclk);
        rd(ADDR_IRQ, v);
        chk(v[IRQ_OVERFLOW], 1'b1, "wrap flag");
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LO, v);
        chk(v, BYTE_ZERO, "disabled low");
        rd(ADDR_COUNT_HI, v);
        chk(v, BYTE_ZERO, "disabled high");
        $display("test free run done");
        close_out();
    end
endmodule // tb_pwm_time_base_event_gen
